/* File: uart_chan_pkg.sv */
// Purpose: constants and carriers for one uart channel register bank
// Assumes: 8-bit register bus, one channel per instance
// Notes:   byte addresses, one register per address
package uart_chan_pkg;
    localparam logic [7:0] ADDR_MASK      = 8'h00;
    localparam logic [7:0] ADDR_RX_FIFO   = 8'h01;
    localparam logic [7:0] ADDR_TX_FIFO   = 8'h02;
    localparam logic [7:0] ADDR_BID_BRK   = 8'h03;
    localparam logic [7:0] ADDR_BID_COS   = 8'h04;
    localparam logic [7:0] ADDR_BID_FLOW  = 8'h05;
    localparam logic [7:0] ADDR_BID_ADDR  = 8'h06;
    localparam logic [7:0] ADDR_RESUME    = 8'h07;
    localparam logic [7:0] ADDR_PAUSE     = 8'h08;
    localparam logic [7:0] ADDR_WAKEUP    = 8'h09;
    localparam logic [7:0] ADDR_FLOW      = 8'h0A;
    localparam logic [7:0] ADDR_WDOG_RUN  = 8'h0B;
    localparam logic [7:0] ADDR_RELOAD_AH = 8'h0C;
    localparam logic [7:0] ADDR_RELOAD_AL = 8'h0D;
    localparam logic [7:0] ADDR_RELOAD_BH = 8'h0E;
    localparam logic [7:0] ADDR_RELOAD_BL = 8'h0F;
    localparam logic [7:0] ADDR_ERR_STAT  = 8'h10;
    localparam logic [7:0] ADDR_SRC_STAT  = 8'h11;
    localparam logic [7:0] ADDR_MODE      = 8'h12;
    localparam logic [7:0] ADDR_COMMAND   = 8'h13;
    // interrupt source bit positions
    localparam int SRC_TX   = 0;
    localparam int SRC_RX   = 1;
    localparam int SRC_BRK  = 2;
    localparam int SRC_FLOW = 4;
    localparam int SRC_ADDR = 5;
    localparam int SRC_WDOG = 6;
    localparam int SRC_COS  = 7;
    localparam logic [7:0] MASK_WRITABLE = 8'hF7;
    // mode register fields
    localparam int MODE_BLOCK = 0;
    localparam int MODE_AUTO  = 1;
    localparam int MODE_LEN   = 2;
    // channel commands
    localparam logic [7:0] CMD_RESET_ERROR = 8'h04;
    localparam logic [7:0] CMD_RESET_BREAK = 8'h05;
    localparam logic [7:0] CMD_RESET_ADDR  = 8'h1B;
    // flow status codes
    localparam logic [1:0] AUTO_XON_SENT  = 2'h1;
    localparam logic [1:0] AUTO_XOFF_SENT = 2'h2;
    localparam logic [1:0] TXFLOW_NORMAL  = 2'h0;
    localparam logic [1:0] TXFLOW_REEN    = 2'h2;
    // reset values and sizes
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [6:0] WDOG_LIMIT = 7'h40;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] PTR_STEP   = 5'h01;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic       push;
        logic [2:0] err;
        logic [7:0] data;
    } rx_push_type;

    typedef struct packed {
        logic [7:0]           mask;
        logic [3:0][2:0]      bid;
        logic [7:0]           resume;
        logic [7:0]           pause;
        logic [7:0]           wake;
        logic [3:0]           wdog_en;
        logic [3:0][7:0]      reload;
        logic [3:0]           mode;
        logic [15:0][10:0]    rxm;
        logic [4:0]           rx_wp;
        logic [4:0]           rx_rp;
        logic [15:0][7:0]     txm;
        logic [4:0]           tx_wp;
        logic [4:0]           tx_rp;
        logic [2:0]           blk_err;
        logic                 input_change_event;
        logic                 wdog;
        logic                 addr;
        logic                 flow;
        logic                 brk;
        logic [1:0]           rx_x;
        logic [1:0]           auto_x;
        logic                 reen_ack;
        logic [6:0]           wcnt;
        logic [10:0]          rdata;
    } state_type;
endpackage

/* File: uart_channel_intr_flow_regs.sv */
// Purpose: per-channel interrupt mask, fifos, bids, flow status, timer reloads
// Assumes: receiver and transmitter logic run on ref_clk_i
// Notes:   read data appear the cycle after the read strobe
//
// Summary of operation
// - a source reaches arbitration and request only when status and mask are one
// - mask bit 7 gates input change of state events
// - mask bit 6 gates the receiver watchdog event
// - mask bit 5 gates address recognition state changes
// - mask bit 4 gates received flow character recognition
// - mask bit 2 gates break change; mask bit 3 reads zero
// - mask bits 1 and 0 gate receive and transmit fifo service
// - receive fifo holds 16 entries: break, framing, parity, eight data bits
// - error bits travel with their character; status shows head entry
// - unused upper data bits are zero for short characters
// - block error mode accumulates errors until reset error command 0x04
// - transmit fifo holds 16 bytes; upper bits of short characters ignored
// - four bid registers give three arbitration msbs; bits 7:3 reserved
// - resume, pause and wakeup compare characters match received data
// - received flow character bits hold until read, regardless of mode
// - last automatic flow character sent; zero when automatic mode off
// - transmitter flow status codes normal, halt pending, re-enabled, disabled
// - re-enabled status shows normal after a flow status read
// - transmit character status codes are reported from the transmitter
// - watchdog run register holds one enable per receiver
// - two baud timers take sixteen-bit divisors from high and low bytes
// - watchdog event after more than 64 bit times; cleared by push or read
// - flow source bit cleared by a flow status read
`timescale 1ns/1ps
module uart_channel_intr_flow_regs #(
    parameter logic [1:0] CHANNEL = 2'h0
) (
    input  wire logic                        ref_clk_i,
    input  wire logic                        nrst_i,
    input  wire uart_chan_pkg::bus_req_type  bus_i,
    output logic [10:0]                      rd_data_o,
    input  wire uart_chan_pkg::rx_push_type  rx_i,
    input  wire logic                        bit_tick_i,
    input  wire logic                        input_change_event_i,
    input  wire logic                        input_port_read_i,
    input  wire logic                        break_change_i,
    input  wire logic                        tx_pop_i,
    input  wire logic                        auto_xon_sent_i,
    input  wire logic                        auto_xoff_sent_i,
    input  wire logic [1:0]                  tx_flow_i,
    input  wire logic [1:0]                  tx_char_i,
    output logic                             interrupt_request_n_o,
    output logic [7:0]                       arb_sources_o,
    output logic [3:0][2:0]                  bids_o,
    output logic                             resume_hit_o,
    output logic                             pause_hit_o,
    output logic                             wakeup_hit_o,
    output logic                             rx_ready_o,
    output logic                             tx_valid_o,
    output logic [7:0]                       tx_data_o,
    output logic                             auto_flow_mode_o,
    output logic [1:0][15:0]                 timer_reload_o
);
    import uart_chan_pkg::*;

    state_type   q;
    state_type   d;
    logic        rx_empty;
    logic        rx_full;
    logic        tx_empty;
    logic        tx_full;
    logic        rx_push;
    logic        rx_pop;
    logic        fifo_evt;
    logic        flow_rd;
    logic [10:0] head;
    logic [7:0]  pdata;
    logic [7:0]  interrupt_source_status;
    logic [7:0]  flow_view;
    logic [1:0]  txflow_view;
    logic [2:0]  err_view;
    logic        cmd_wr;

    // zero data bits above the programmed character length
    function automatic logic [7:0] len_mask(input logic [7:0] v, input logic [1:0] len);
        logic [7:0] m;
        m = 8'hFF >> (2'h3 - len);
        return v & m;
    endfunction

    always_comb begin
        d = q;
        rx_empty = (q.rx_wp == q.rx_rp);
        rx_full  = ((q.rx_wp - q.rx_rp) == FIFO_DEPTH);
        tx_empty = (q.tx_wp == q.tx_rp);
        tx_full  = ((q.tx_wp - q.tx_rp) == FIFO_DEPTH);
        head     = q.rxm[q.rx_rp[3:0]];
        pdata    = len_mask(rx_i.data, q.mode[MODE_LEN +: 2]);
        rx_push  = rx_i.push && !rx_full;
        rx_pop   = bus_i.rd && (bus_i.addr == ADDR_RX_FIFO) && !rx_empty;
        fifo_evt = rx_push || rx_pop;
        flow_rd  = bus_i.rd && (bus_i.addr == ADDR_FLOW);
        cmd_wr   = bus_i.wr && (bus_i.addr == ADDR_COMMAND);
        resume_hit_o = rx_push && (pdata == q.resume);
        pause_hit_o  = rx_push && (pdata == q.pause);
        wakeup_hit_o = rx_push && (pdata == q.wake);
        interrupt_source_status = {q.input_change_event, q.wdog, q.addr, q.flow, 1'b0, q.brk, !rx_empty, tx_empty};
        txflow_view = (tx_flow_i == TXFLOW_REEN && q.reen_ack) ? TXFLOW_NORMAL : tx_flow_i;
        // automatic status hidden when mode off
        flow_view = {q.rx_x, q.mode[MODE_AUTO] ? q.auto_x : 2'h0, txflow_view, tx_char_i};
        err_view = q.mode[MODE_BLOCK] ? q.blk_err : (rx_empty ? 3'h0 : head[10:8]);

        d.rdata = 11'h000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_MASK:      d.rdata = {3'h0, q.mask};
                ADDR_RX_FIFO:   d.rdata = rx_empty ? 11'h000 : head;
                ADDR_BID_BRK:   d.rdata = {8'h00, q.bid[0]};
                ADDR_BID_COS:   d.rdata = {8'h00, q.bid[1]};
                ADDR_BID_FLOW:  d.rdata = {8'h00, q.bid[2]};
                ADDR_BID_ADDR:  d.rdata = {8'h00, q.bid[3]};
                ADDR_RESUME:    d.rdata = {3'h0, q.resume};
                ADDR_PAUSE:     d.rdata = {3'h0, q.pause};
                ADDR_WAKEUP:    d.rdata = {3'h0, q.wake};
                ADDR_FLOW:      d.rdata = {3'h0, flow_view};
                ADDR_WDOG_RUN:  d.rdata = {7'h00, q.wdog_en};
                ADDR_RELOAD_AH: d.rdata = {3'h0, q.reload[0]};
                ADDR_RELOAD_AL: d.rdata = {3'h0, q.reload[1]};
                ADDR_RELOAD_BH: d.rdata = {3'h0, q.reload[2]};
                ADDR_RELOAD_BL: d.rdata = {3'h0, q.reload[3]};
                ADDR_ERR_STAT:  d.rdata = {8'h00, err_view};
                ADDR_SRC_STAT:  d.rdata = {3'h0, interrupt_source_status};
                ADDR_MODE:      d.rdata = {7'h00, q.mode};
                default:        d.rdata = 11'h000;
            endcase
        end

        if (bus_i.wr) begin
            case (bus_i.addr)
                // mask bit 3 held at zero
                ADDR_MASK:      d.mask = bus_i.wdata & MASK_WRITABLE;
                ADDR_BID_BRK:   d.bid[0] = bus_i.wdata[2:0];
                ADDR_BID_COS:   d.bid[1] = bus_i.wdata[2:0];
                ADDR_BID_FLOW:  d.bid[2] = bus_i.wdata[2:0];
                ADDR_BID_ADDR:  d.bid[3] = bus_i.wdata[2:0];
                ADDR_RESUME:    d.resume = bus_i.wdata;
                ADDR_PAUSE:     d.pause = bus_i.wdata;
                ADDR_WAKEUP:    d.wake = bus_i.wdata;
                ADDR_WDOG_RUN:  d.wdog_en = bus_i.wdata[3:0];
                ADDR_RELOAD_AH: d.reload[0] = bus_i.wdata;
                ADDR_RELOAD_AL: d.reload[1] = bus_i.wdata;
                ADDR_RELOAD_BH: d.reload[2] = bus_i.wdata;
                ADDR_RELOAD_BL: d.reload[3] = bus_i.wdata;
                ADDR_MODE:      d.mode = bus_i.wdata[3:0];
                default:        d.mode = q.mode;
            endcase
        end

        if (rx_push) begin
            d.rxm[q.rx_wp[3:0]] = {rx_i.err, pdata};
            d.rx_wp = q.rx_wp + PTR_STEP;
        end
        if (rx_pop) begin
            d.rx_rp = q.rx_rp + PTR_STEP;
        end
        if (bus_i.wr && (bus_i.addr == ADDR_TX_FIFO) && !tx_full) begin
            d.txm[q.tx_wp[3:0]] = bus_i.wdata;
            d.tx_wp = q.tx_wp + PTR_STEP;
        end
        if (tx_pop_i && !tx_empty) begin
            d.tx_rp = q.tx_rp + PTR_STEP;
        end

        d.blk_err = ((cmd_wr && bus_i.wdata == CMD_RESET_ERROR) ? 3'h0 : q.blk_err)
                  | (rx_push ? rx_i.err : 3'h0);
        d.brk  = ((cmd_wr && bus_i.wdata == CMD_RESET_BREAK) ? 1'b0 : q.brk) | break_change_i;
        d.addr = ((cmd_wr && bus_i.wdata == CMD_RESET_ADDR) ? 1'b0 : q.addr) | wakeup_hit_o;
        d.input_change_event  = (input_port_read_i ? 1'b0 : q.input_change_event) | input_change_event_i;
        // received flow characters held until read
        d.rx_x = (flow_rd ? 2'h0 : q.rx_x) | {resume_hit_o, pause_hit_o};
        d.flow = (flow_rd ? 1'b0 : q.flow) | resume_hit_o | pause_hit_o;
        // last automatic character, cleared when mode off
        if (!d.mode[MODE_AUTO]) begin
            d.auto_x = 2'h0;
        end else if (auto_xoff_sent_i) begin
            d.auto_x = AUTO_XOFF_SENT;
        end else if (auto_xon_sent_i) begin
            d.auto_x = AUTO_XON_SENT;
        end
        if (tx_flow_i != TXFLOW_REEN) begin
            d.reen_ack = 1'b0;
        end else if (flow_rd) begin
            d.reen_ack = 1'b1;
        end

        // idle bit-time count since last fifo event
        if (fifo_evt) begin
            d.wcnt = 7'h00;
            d.wdog = 1'b0;
        end else begin
            if (q.wdog_en[CHANNEL] && bit_tick_i && (q.wcnt <= WDOG_LIMIT)) begin
                d.wcnt = q.wcnt + 7'h01;
            end
            d.wdog = q.wdog | (q.wcnt > WDOG_LIMIT);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.mask <= BYTE_RST;
        end else begin
            q <= d;
        end
    end

    assign arb_sources_o = interrupt_source_status & q.mask;
    assign interrupt_request_n_o = !(|arb_sources_o);
    assign rd_data_o = q.rdata;
    assign bids_o = q.bid;
    assign rx_ready_o = !rx_full;
    assign tx_valid_o = !tx_empty;
    // upper bits of short characters dropped
    assign tx_data_o = len_mask(q.txm[q.tx_rp[3:0]], q.mode[MODE_LEN +: 2]);
    assign auto_flow_mode_o = q.mode[MODE_AUTO];
    assign timer_reload_o = {{q.reload[2], q.reload[3]}, {q.reload[0], q.reload[1]}};

    a_masked_no_req: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ((interrupt_source_status & q.mask) == 8'h00) |-> interrupt_request_n_o)
        else $error("masked source drove request");

    a_cos_gated_req: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (q.input_change_event && q.mask[SRC_COS]) |-> !interrupt_request_n_o && arb_sources_o[SRC_COS])
        else $error("change of state not presented");

    a_wdog_after_64: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(q.wdog) |-> $past(q.wcnt) > WDOG_LIMIT && !$past(fifo_evt))
        else $error("watchdog set early");

    a_wdog_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (q.wdog && !q.mask[SRC_WDOG]) |-> !arb_sources_o[SRC_WDOG])
        else $error("watchdog passed while masked");

    a_wdog_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        fifo_evt |=> !q.wdog && q.wcnt == 7'd0)
        else $error("watchdog not cleared by fifo event");

    a_mask_bit3: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        bus_i.wr && bus_i.addr == ADDR_MASK |=> !q.mask[3] && q.mask[7] == $past(bus_i.wdata[7]))
        else $error("mask write wrong");

    a_rx_read_head: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        rx_pop |=> rd_data_o == $past(head) && q.rx_rp == $past(q.rx_rp) + 5'd1)
        else $error("receive fifo read wrong");

    a_rx_depth: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (q.rx_wp - q.rx_rp) <= FIFO_DEPTH && (q.tx_wp - q.tx_rp) <= FIFO_DEPTH)
        else $error("fifo depth exceeded");

    a_short_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        rx_push && q.mode[MODE_LEN +: 2] == 2'h0 |=> q.rxm[$past(q.rx_wp[3:0])][7:5] == 3'h0)
        else $error("short character upper bits kept");

    a_blk_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        cmd_wr && bus_i.wdata == CMD_RESET_ERROR && !rx_push |=> q.blk_err == 3'h0)
        else $error("reset error command ignored");

    a_bid_reserved: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        bus_i.rd && bus_i.addr == ADDR_BID_COS |=> rd_data_o[10:3] == 8'h00)
        else $error("bid reserved bits not zero");

    a_flow_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        q.rx_x != 2'h0 && !flow_rd |=> (q.rx_x & $past(q.rx_x)) == $past(q.rx_x))
        else $error("received flow bits lost without read");

    a_auto_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !q.mode[MODE_AUTO] |-> q.auto_x == 2'h0)
        else $error("automatic status kept with mode off");

    a_flow_src_clr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        flow_rd && !resume_hit_o && !pause_hit_o |=> !q.flow && q.rx_x == 2'h0)
        else $error("flow read did not clear");

    a_reen_normal: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        flow_rd && tx_flow_i == TXFLOW_REEN ##1 tx_flow_i == TXFLOW_REEN
            |-> flow_view[3:2] == TXFLOW_NORMAL)
        else $error("re-enabled not returned to normal");
endmodule // uart_channel_intr_flow_regs

/* File: uart_host_model.sv */
// Purpose: host cpu model on the register bus of one channel
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes:   tasks are called by the bench
`timescale 1ns/1ps
module uart_host_model (
    input  wire logic                  ref_clk_i,
    input  wire logic [10:0]           rd_data_i,
    output uart_chan_pkg::bus_req_type bus_o
);
    import uart_chan_pkg::*;
    initial bus_o = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge ref_clk_i);
        bus_o <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus_o.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [10:0] dt);
        @(posedge ref_clk_i);
        bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus_o.rd <= 1'b0;
        #1 dt = rd_data_i;
    endtask
    task automatic leave_auto(input logic [7:0] md, input logic [7:0] res, input logic paused);
        wr(ADDR_MODE, md & 8'hFD);
        if (paused) wr(ADDR_TX_FIFO, res);
    endtask
endmodule // uart_host_model

/* File: uart_channel_intr_flow_regs_tb.sv */
// Purpose: self-checking bench for the channel register bank
// Assumes: host model drives the bus, bench drives the channel side
// Notes:   expectations come from queues and integers in the bench
`timescale 1ns/1ps
module uart_channel_intr_flow_regs_tb;
    import uart_chan_pkg::*;
    logic                  ref_clk_i, nrst_i, tick, cev, prd, brk, pop, axon, axoff;
    logic [1:0]            txf, txc;
    bus_req_type           bus;
    rx_push_type           rx;
    logic [10:0]           rdd, d;
    logic                  irq_n, hr, hp, hw, rxr, txv, afm;
    logic [7:0]            arb, txd, v, m, src, lm;
    logic [3:0][2:0]       bids;
    logic [1:0][15:0]      rel;
    logic [7:0]            val [16];
    logic [10:0]           rxq [$];
    logic [7:0]            txq [$];
    int                    n_fail, num_checks, cyc, i;
    uart_host_model h (.ref_clk_i(ref_clk_i), .rd_data_i(rdd), .bus_o(bus));
    uart_channel_intr_flow_regs #(.CHANNEL(2'h0)) DUT (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rd_data_o(rdd),
        .rx_i(rx), .bit_tick_i(tick), .input_change_event_i(cev),
        .input_port_read_i(prd), .break_change_i(brk), .tx_pop_i(pop),
        .auto_xon_sent_i(axon), .auto_xoff_sent_i(axoff), .tx_flow_i(txf),
        .tx_char_i(txc), .interrupt_request_n_o(irq_n), .arb_sources_o(arb),
        .bids_o(bids), .resume_hit_o(hr), .pause_hit_o(hp), .wakeup_hit_o(hw),
        .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
        .auto_flow_mode_o(afm), .timer_reload_o(rel));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [10:0] e);
        h.rd(a, d);
        chk(d, e);
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        {cev, prd, brk, pop, axoff, tick, axon} <= 7'h40 >> k;
        @(posedge ref_clk_i);
        {cev, prd, brk, pop, axoff, tick, axon} <= 7'h00;
    endtask
    task automatic push(input logic [2:0] e, input logic [7:0] dd);
        logic [7:0] md;
        md = dd & lm;
        @(posedge ref_clk_i);
        rx <= '{push: 1'b1, err: e, data: dd};
        #1;
        if (rxq.size() < 16) begin
            chk({hr, hp, hw}, {md == val[7], md == val[8], md == val[9]});
            rxq.push_back({e, md});
        end
        @(posedge ref_clk_i);
        rx.push <= 1'b0;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        {nrst_i, tick, cev, prd, brk, pop, axon, axoff, txf, txc} = '0;
        rx = '0;
        lm = 8'hFF;
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        v = 8'($urandom(32'h5bb5));
        for (i = 0; i < 16; i++) begin
            if (i == 1 || i == 2 || i == 10) continue;
            m = (i == 0) ? 8'hF7 : (i >= 3 && i <= 6) ? 8'h07 : (i == 11) ? 8'h0F : 8'hFF;
            rchk(8'(i), 11'h000);
            v = 8'($urandom);
            h.wr(8'(i), v);
            val[i] = v & m;
            rchk(8'(i), {3'h0, val[i]});
        end
        chk(bids, {val[6][2:0], val[5][2:0], val[4][2:0], val[3][2:0]});
        chk(rel, {val[14], val[15], val[12], val[13]});
        h.wr(8'h20, 8'hFF);
        rchk(8'h20, 11'h000);
        h.wr(ADDR_MODE, 8'h0C);
        for (i = 0; i < 17; i++) push(3'($urandom), (i == 3) ? val[7] : 8'($urandom));
        #1 chk(rxr, 1'b0);
        for (i = 0; i < 16; i++) begin
            rchk(ADDR_ERR_STAT, {8'h00, rxq[0][10:8]});
            rchk(ADDR_RX_FIFO, rxq.pop_front());
        end
        rchk(ADDR_RX_FIFO, 11'h000);
        for (i = 0; i < 4; i++) begin
            h.wr(ADDR_MODE, 8'(i << 2));
            lm = 8'hFF >> (3 - i);
            push(3'h5, 8'hFF);
            rchk(ADDR_RX_FIFO, rxq.pop_front());
        end
        h.wr(ADDR_MODE, 8'h0D);
        h.wr(ADDR_COMMAND, CMD_RESET_ERROR);
        push(3'h1, 8'h41);
        push(3'h2, 8'h42);
        rchk(ADDR_ERR_STAT, 11'h003);
        repeat (2) rchk(ADDR_RX_FIFO, rxq.pop_front());
        rchk(ADDR_ERR_STAT, 11'h003);
        h.wr(ADDR_COMMAND, CMD_RESET_ERROR);
        rchk(ADDR_ERR_STAT, 11'h000);
        h.wr(ADDR_MODE, 8'h08);
        for (i = 0; i < 17; i++) begin
            v = 8'($urandom);
            h.wr(ADDR_TX_FIFO, v);
            if (i < 16) txq.push_back(v);
        end
        #1 chk(txv, 1'b1);
        for (i = 0; i < 16; i++) begin
            chk(txd, txq.pop_front() & 8'h7F);
            pulse(3);
            #1;
        end
        chk(txv, 1'b0);
        h.wr(ADDR_MODE, 8'h0C);
        h.rd(ADDR_FLOW, d);
        @(posedge ref_clk_i);
        txf <= 2'h1;
        txc <= 2'($urandom);
        push(3'h0, val[8]);
        push(3'h0, val[7]);
        pulse(4);
        rchk(ADDR_FLOW, {3'h0, 2'h3, 2'h0, 2'h1, txc});
        rchk(ADDR_FLOW, {3'h0, 2'h0, 2'h0, 2'h1, txc});
        h.rd(ADDR_SRC_STAT, d);
        chk(d[SRC_FLOW], 1'b0);
        h.wr(ADDR_MODE, 8'h0E);
        pulse(6);
        chk(afm, 1'b1);
        rchk(ADDR_FLOW, {3'h0, 2'h0, AUTO_XON_SENT, 2'h1, txc});
        @(posedge ref_clk_i);
        txf <= TXFLOW_REEN;
        pulse(4);
        rchk(ADDR_FLOW, {3'h0, 2'h0, AUTO_XOFF_SENT, TXFLOW_REEN, txc});
        rchk(ADDR_FLOW, {3'h0, 2'h0, AUTO_XOFF_SENT, TXFLOW_NORMAL, txc});
        h.leave_auto(8'h0E, val[7], 1'b1);
        rchk(ADDR_FLOW, {3'h0, 2'h0, 2'h0, TXFLOW_NORMAL, txc});
        chk(txd, val[7]);
        pulse(3);
        h.wr(ADDR_WDOG_RUN, 8'h00);
        h.wr(ADDR_COMMAND, CMD_RESET_BREAK);
        h.wr(ADDR_COMMAND, CMD_RESET_ADDR);
        h.rd(ADDR_FLOW, d);
        pulse(1);
        pulse(0);
        pulse(2);
        push(3'h0, val[9]);
        push(3'h0, val[8]);
        src = {6'b101101, rxq.size() != 0, 1'b1};
        for (i = 0; i < 10; i++) begin
            m = (i == 0) ? 8'hFF : 8'($urandom);
            h.wr(ADDR_MASK, m);
            #1 chk(arb, src & m & MASK_WRITABLE);
            chk(irq_n, (src & m & MASK_WRITABLE) == 8'h00);
        end
        h.wr(ADDR_MASK, 8'h40);
        h.wr(ADDR_WDOG_RUN, 8'h01);
        push(3'h0, 8'h00);
        // 64 idle bit times are not yet more than 64
        repeat (64) pulse(5);
        @(posedge ref_clk_i);
        #1 chk(arb, 8'h00);
        pulse(5);
        @(posedge ref_clk_i);
        #1 chk({irq_n, arb}, 9'h040);
        h.wr(ADDR_MASK, 8'h00);
        #1 chk({irq_n, arb}, 9'h100);
        h.wr(ADDR_MASK, 8'h40);
        rchk(ADDR_RX_FIFO, rxq.pop_front());
        chk(arb, 8'h00);
        summarize();
    end
endmodule // uart_channel_intr_flow_regs_tb
